// ===== src/stepper_phase_translator.sv
// Stepper translator with dual chopper and APB control/status registers
//
// The APB register port and the address map were decided locally.
module stepper_phase_translator (
  // Clock and reset
  input  wire logic                                pclk,
  input  wire logic                                presetn,
  // APB slave
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [11:0]                         paddr,
  input  wire logic [31:0]                         pwdata,
  output logic      [31:0]                         prdata,
  output logic                                     pready,
  output logic                                     pslverr,
  // Host step interface
  input  wire logic                                step_n,
  input  wire logic                                rotation_sense,
  input  wire logic                                step_size_select,
  input  wire logic                                enable,
  input  wire logic                                reset_n,
  input  wire logic                                chop_target_select,
  // Peak current comparators
  input  wire logic                                current_feedback_ab,
  input  wire logic                                current_feedback_cd,
  // Bridge drive
  output stepper_phase_translator_pkg::phase_t     phase_drive,
  output stepper_phase_translator_pkg::inhibit_t   inhibit_drive,
  // Home flag, open collector pin
  input  wire logic                                initial_state_flag_in,
  output logic                                     initial_state_flag_out,
  output logic                                     initial_state_flag_oe,
  // Shared chopper oscillator pin
  input  wire logic                                chopper_osc_pin_in,
  output logic                                     chopper_osc_pin_out,
  output logic                                     chopper_osc_pin_oe
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [15:0] chop_period_q;
  logic        ext_osc_q;
  logic [2:0]  state_q;
  logic [2:0]  state_d;
  logic        step_prev_q;
  logic        dir_meta_q;
  logic        dir_sync_q;
  logic [15:0] osc_cnt_q;
  logic [15:0] osc_cnt_d;
  logic        osc_in_prev_q;
  logic        chop_latch_ab;
  logic        chop_latch_cd;
  logic        pready_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  stepper_phase_translator_pkg::phase_t   phase_q;
  stepper_phase_translator_pkg::inhibit_t inhibit_q;
  logic        home_oe_q;
  logic        osc_out_q;
  logic        osc_oe_q;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire logic        apb_access = psel & penable & ~pready_q;
  wire logic        sel_ctrl   = (paddr == stepper_phase_translator_pkg::CTRL_OFFSET);
  wire logic        sel_status = (paddr == stepper_phase_translator_pkg::STATUS_OFFSET);
  wire logic        unmapped   = ~sel_ctrl & ~sel_status;
  wire logic        ctrl_write = apb_access & pwrite & sel_ctrl;
  logic      [31:0] ctrl_word;
  logic      [31:0] status_word;
  logic      [31:0] read_word;

  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[stepper_phase_translator_pkg::CTRL_PERIOD_LSB +: 16] = chop_period_q;
    ctrl_word[stepper_phase_translator_pkg::CTRL_EXT_OSC_BIT]      = ext_osc_q;
    status_word = 32'h0000_0000;
    status_word[stepper_phase_translator_pkg::STAT_STATE_LSB +: 3] = state_q;
    status_word[stepper_phase_translator_pkg::STAT_HOME_BIT]       = initial_state_flag_in;
    status_word[stepper_phase_translator_pkg::STAT_LATCH_LSB +: 2] = {chop_latch_ab,
                                                                      chop_latch_cd};
    status_word[stepper_phase_translator_pkg::STAT_PHASE_LSB +: 4] = phase_q;
    status_word[stepper_phase_translator_pkg::STAT_INH_LSB +: 2]   = inhibit_q;
  end

  assign read_word = sel_ctrl ? ctrl_word : (sel_status ? status_word : 32'h0000_0000);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= apb_access;
      pslverr_q <= apb_access & unmapped;
      if (apb_access && !pwrite) begin
        prdata_q <= read_word;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chop_period_q <= stepper_phase_translator_pkg::CHOP_PERIOD_RESET;
      ext_osc_q     <= stepper_phase_translator_pkg::EXT_OSC_RESET;
    end else if (ctrl_write) begin
      chop_period_q <= pwdata[stepper_phase_translator_pkg::CTRL_PERIOD_LSB +: 16];
      ext_osc_q     <= pwdata[stepper_phase_translator_pkg::CTRL_EXT_OSC_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Translator
  // ----------------------------------------------------------------
  wire logic       step_rise = step_n & ~step_prev_q;
  wire logic [2:0] step_inc  = step_size_select ? stepper_phase_translator_pkg::HALF_INC
                                                : stepper_phase_translator_pkg::FULL_INC;

  // Full step keeps parity: even start gives two-phase-on, odd start gives wave
  always_comb begin
    state_d = state_q;
    if (!reset_n) begin
      state_d = stepper_phase_translator_pkg::HOME_STATE;
    end else if (step_rise) begin
      if (dir_sync_q) begin
        state_d = state_q - step_inc;
      end else begin
        state_d = state_q + step_inc;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q     <= stepper_phase_translator_pkg::HOME_STATE;
      step_prev_q <= 1'b1;
      dir_meta_q  <= 1'b0;
      dir_sync_q  <= 1'b0;
    end else begin
      state_q     <= state_d;
      step_prev_q <= step_n;
      dir_meta_q  <= rotation_sense;
      dir_sync_q  <= dir_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Chopper oscillator on the shared pin
  // ----------------------------------------------------------------
  wire logic osc_wrap  = (osc_cnt_q >= chop_period_q - 16'h0001) | (chop_period_q == 16'h0000);
  wire logic ext_pulse = chopper_osc_pin_in & ~osc_in_prev_q;
  wire logic osc_pulse = ext_osc_q ? ext_pulse : osc_wrap;

  assign osc_cnt_d = (osc_wrap | ext_osc_q) ? 16'h0000 : osc_cnt_q + 16'h0001;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_cnt_q     <= 16'h0000;
      osc_in_prev_q <= 1'b0;
      osc_out_q     <= 1'b0;
      osc_oe_q      <= 1'b0;
    end else begin
      osc_cnt_q     <= osc_cnt_d;
      osc_in_prev_q <= chopper_osc_pin_in;
      osc_out_q     <= ~ext_osc_q & osc_wrap;
      osc_oe_q      <= ~ext_osc_q;
    end
  end

  // ----------------------------------------------------------------
  // Chop latches: oscillator pulse sets, peak current clears
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chop_latch_ab <= 1'b1;
      chop_latch_cd <= 1'b1;
    end else begin
      chop_latch_ab <= osc_pulse | (chop_latch_ab & ~current_feedback_ab);
      chop_latch_cd <= osc_pulse | (chop_latch_cd & ~current_feedback_cd);
    end
  end

  // ----------------------------------------------------------------
  // Output shaping
  // ----------------------------------------------------------------
  wire logic [3:0] base_phase = stepper_phase_translator_pkg::STEP_TABLE[{state_d, 2'b00} +: 4];
  wire logic       pair_ab_on = base_phase[3] | base_phase[2];
  wire logic       pair_cd_on = base_phase[1] | base_phase[0];
  wire logic       chop_phase = chop_target_select;
  // Idle pair inhibited; even states energise both, so both stay high unless inhibit-chopped
  wire logic       inh_ab_n   = pair_ab_on & (chop_phase | chop_latch_ab);
  wire logic       inh_cd_n   = pair_cd_on & (chop_phase | chop_latch_cd);
  // Chopped phase pair turns both lines on instead of dropping the active one
  wire logic       fill_ab    = chop_phase & ~chop_latch_ab & pair_ab_on;
  wire logic       fill_cd    = chop_phase & ~chop_latch_cd & pair_cd_on;
  wire logic [3:0] out_phase  = base_phase | {fill_ab, fill_ab, fill_cd, fill_cd};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q   <= '0;
      inhibit_q <= '0;
      home_oe_q <= 1'b0;
    end else begin
      phase_q   <= enable ? out_phase : 4'h0;
      inhibit_q <= enable ? {inh_ab_n, inh_cd_n} : 2'b00;
      home_oe_q <= (base_phase != stepper_phase_translator_pkg::HOME_PHASES);
    end
  end

  assign phase_drive            = phase_q;
  assign inhibit_drive          = inhibit_q;
  assign initial_state_flag_out = 1'b0;
  assign initial_state_flag_oe  = home_oe_q;
  assign chopper_osc_pin_out    = osc_out_q;
  assign chopper_osc_pin_oe     = osc_oe_q;
  assign prdata                 = prdata_q;
  assign pready                 = pready_q;
  assign pslverr                = pslverr_q;

endmodule : stepper_phase_translator

// ===== src/stepper_phase_translator_pkg.sv
// Constants, field layouts and carrier types of the stepper phase translator
package stepper_phase_translator_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] CTRL_OFFSET   = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;

  // ----------------------------------------------------------------
  // Control register fields and reset values
  // ----------------------------------------------------------------
  localparam int          CTRL_PERIOD_LSB   = 0;
  localparam int          CTRL_PERIOD_W     = 16;
  localparam int          CTRL_EXT_OSC_BIT  = 16;
  // 250 MHz / 12500 cycles gives a 20 kHz chopper rate
  localparam logic [15:0] CHOP_PERIOD_RESET = 16'h30D4;
  localparam logic        EXT_OSC_RESET     = 1'b0;

  // ----------------------------------------------------------------
  // Status register fields
  // ----------------------------------------------------------------
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_HOME_BIT  = 3;
  localparam int STAT_LATCH_LSB = 4;
  localparam int STAT_PHASE_LSB = 6;
  localparam int STAT_INH_LSB   = 10;

  // ----------------------------------------------------------------
  // Translator
  // ----------------------------------------------------------------
  localparam logic [2:0] HOME_STATE = 3'h0;
  localparam logic [2:0] HALF_INC   = 3'h1;
  localparam logic [2:0] FULL_INC   = 3'h2;
  // Phase pattern ABCD per state, state 0 (index 0) in the low nibble
  localparam logic [31:0] STEP_TABLE = 32'h198A2645;
  localparam logic [3:0]  HOME_PHASES = 4'h5;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic a;
    logic b;
    logic c;
    logic d;
  } phase_t;

  typedef struct packed {
    logic ab_n;
    logic cd_n;
  } inhibit_t;

endpackage : stepper_phase_translator_pkg

// ===== verification/step_checker_assertions.sv
// Port-level property checker for the stepper phase translator
module step_checker (
  // Clock and reset
  input wire logic                                   pclk,
  input wire logic                                   presetn,
  // Observed ports
  input wire logic                                   pready,
  input wire logic                                   pslverr,
  input wire logic                                   step_n,
  input wire logic                                   enable,
  input wire logic                                   reset_n,
  input wire logic                                   chop_target_select,
  input wire stepper_phase_translator_pkg::phase_t   phase_drive,
  input wire stepper_phase_translator_pkg::inhibit_t inhibit_drive,
  input wire logic                                   initial_state_flag_out,
  input wire logic                                   initial_state_flag_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_off;
    !enable ##1 !enable;
  endsequence
  // No step edge, no control change and chop_target_select low: phases must not move
  sequence s_quiet;
    $past(presetn) && $stable(step_n) && $stable(enable) && $stable(reset_n)
      && !chop_target_select && $stable(chop_target_select);
  endsequence
  property p_home;
    phase_drive == 4'h5 |-> !initial_state_flag_oe && !initial_state_flag_out;
  endproperty
  property p_ab_idle;
    !phase_drive.a && !phase_drive.b |-> !inhibit_drive.ab_n;
  endproperty
  property p_cd_idle;
    !phase_drive.c && !phase_drive.d |-> !inhibit_drive.cd_n;
  endproperty
  property p_enable;
    s_off |-> phase_drive == 4'h0 && inhibit_drive == 2'h0;
  endproperty
  property p_reset;
    !reset_n && enable && !chop_target_select |=> phase_drive == 4'h5;
  endproperty
  property p_hold;
    s_quiet |=> $stable(phase_drive);
  endproperty
  property p_wire;
    !chop_target_select && !$past(chop_target_select)
      |-> !(phase_drive.a && phase_drive.b) && !(phase_drive.c && phase_drive.d);
  endproperty
  property p_ready;
    pready |=> !pready;
  endproperty
  property p_err;
    pslverr |-> pready;
  endproperty
  a_home: assert property (p_home) else $error("home flag wrong at home pattern");
  a_ab_idle: assert property (p_ab_idle) else $error("idle pair ab not inhibited");
  a_cd_idle: assert property (p_cd_idle) else $error("idle pair cd not inhibited");
  a_enable: assert property (p_enable) else $error("outputs live while disabled");
  a_reset: assert property (p_reset) else $error("reset input did not give home");
  a_hold: assert property (p_hold) else $error("phases moved without step edge");
  a_wire: assert property (p_wire) else $error("phase lines chopped in inhibit mode");
  a_ready: assert property (p_ready) else $error("pready longer than one cycle");
  a_err: assert property (p_err) else $error("pslverr without pready");
endmodule : step_checker

bind stepper_phase_translator step_checker u_chk (.*);

// ===== verification/step_host.sv
// Host-side step pulse source facing the translator
module step_host (
  // Clock and request
  input  wire logic pclk,
  input  wire logic go,
  // Step line
  output logic      step_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt_q = 2'h0;
  // One two-cycle low pulse per request, one increment each
  always @(posedge pclk) begin
    if (go) begin
      cnt_q <= 2'h2;
    end else if (cnt_q != 2'h0) begin
      cnt_q <= cnt_q - 2'h1;
    end
  end
  assign step_n = (cnt_q == 2'h0);
endmodule : step_host

// ===== verification/stepper_phase_translator_tb.sv
// Self-checking bench for the stepper phase translator
module stepper_phase_translator_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, go, step_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        rotation_sense, step_size_select, enable, reset_n, chop_target_select;
  logic        current_feedback_ab, current_feedback_cd, ext_osc;
  logic        initial_state_flag_out, initial_state_flag_oe;
  logic        chopper_osc_pin_out, chopper_osc_pin_oe;
  stepper_phase_translator_pkg::phase_t   phase_drive;
  stepper_phase_translator_pkg::inhibit_t inhibit_drive;
  int          n_fail = 0, check_count = 0, cycles = 0, pulses;
  // Pulled-up home line and shared oscillator line
  wire         home_w = initial_state_flag_oe ? initial_state_flag_out : 1'b1;
  wire         osc_w  = chopper_osc_pin_oe ? chopper_osc_pin_out : ext_osc;
  wire  [31:0] outs   = {26'h0, phase_drive, inhibit_drive};

  stepper_phase_translator u_dut (.*, .initial_state_flag_in(home_w),
                                  .chopper_osc_pin_in(osc_w));
  step_host u_host (.pclk(pclk), .go(go), .step_n(step_n));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    if (n_fail == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask : chk
  task automatic cy(int n);
    repeat (n) @(posedge pclk);
  endtask : cy
  task automatic stp();
    @(posedge pclk);
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    cy(4);
    @(negedge pclk);
  endtask : stp
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    @(negedge pclk);
  endtask : apb
  // Feedback pulse and optional external oscillator edge, driven in the same cycle
  task automatic pulse(logic fb, logic osc);
    @(posedge pclk);
    {current_feedback_ab, current_feedback_cd, ext_osc} <= {fb, fb, osc};
    @(posedge pclk);
    {current_feedback_ab, current_feedback_cd, ext_osc} <= 3'h0;
    cy(5);
    @(negedge pclk);
  endtask : pulse
  function automatic logic [31:0] xo(int i);
    logic [3:0] p;
    p = stepper_phase_translator_pkg::STEP_TABLE[i*4 +: 4];
    return {26'h0, p, |p[3:2], |p[1:0]};
  endfunction : xo

  task automatic t_regs();
    apb(1'b0, 12'h000, 32'h0);
    chk("ctrl reset", 32'h30D4, rd);
    apb(1'b0, 12'h008, 32'h0);
    chk("unmapped err", 32'h1, err);
    chk("unmapped data", 32'h0, rd);
    chk("home outputs", xo(0), outs);
    chk("home flag", 32'h0, initial_state_flag_oe);
    chk("home out", 32'h0, initial_state_flag_out);
  endtask : t_regs
  task automatic t_half();
    for (int i = 1; i <= 8; i++) begin
      stp();
      chk("half step", xo(i % 8), outs);
      chk("home flag", (i % 8) != 0, initial_state_flag_oe);
    end
  endtask : t_half
  task automatic t_rev();
    @(posedge pclk);
    rotation_sense <= 1'b1;
    stp();
    chk("reverse 1", xo(7), outs);
    stp();
    chk("reverse 2", xo(6), outs);
    @(posedge pclk);
    rotation_sense <= 1'b0;
  endtask : t_rev
  task automatic t_full();
    @(posedge pclk);
    step_size_select <= 1'b0;
    stp();
    chk("two on 1", xo(0), outs);
    stp();
    chk("two on 2", xo(2), outs);
    @(posedge pclk);
    step_size_select <= 1'b1;
    stp();
    @(posedge pclk);
    step_size_select <= 1'b0;
    stp();
    chk("one on", xo(5), outs);
    @(posedge pclk);
    step_size_select <= 1'b1;
  endtask : t_full
  task automatic t_ctl();
    @(posedge pclk);
    reset_n <= 1'b0;
    @(posedge pclk);
    reset_n <= 1'b1;
    @(negedge pclk);
    chk("reset input", xo(0), outs);
    @(posedge pclk);
    enable <= 1'b0;
    cy(2);
    @(negedge pclk);
    chk("disabled", 32'h0, outs);
    @(posedge pclk);
    enable <= 1'b1;
    cy(1);
    @(negedge pclk);
    chk("enabled", xo(0), outs);
  endtask : t_ctl
  task automatic t_chop();
    apb(1'b1, 12'h000, 32'h0001_0010);
    chk("ext osc oe", 32'h0, chopper_osc_pin_oe);
    pulse(1'b1, 1'b0);
    chk("inh chopped", 32'h14, outs);
    apb(1'b0, 12'h004, 32'h0);
    chk("status", 32'h148, rd);
    pulse(1'b0, 1'b1);
    chk("osc sets", xo(0), outs);
    @(posedge pclk);
    chop_target_select <= 1'b1;
    pulse(1'b1, 1'b0);
    chk("phase chopped", 32'h3F, outs);
    pulse(1'b0, 1'b1);
    chk("phase restored", 32'h17, outs);
    @(posedge pclk);
    chop_target_select <= 1'b0;
  endtask : t_chop
  task automatic t_osc();
    apb(1'b1, 12'h000, 32'h0000_0010);
    chk("int osc oe", 32'h1, chopper_osc_pin_oe);
    pulses = 0;
    repeat (64) begin
      @(posedge pclk);
      if (chopper_osc_pin_out === 1'b1) pulses++;
    end
    chk("osc pulses", 32'h4, pulses);
  endtask : t_osc

  initial begin
    {psel, penable, pwrite, paddr, pwdata, go, presetn, rotation_sense} = '0;
    {current_feedback_ab, current_feedback_cd, ext_osc, chop_target_select} = '0;
    {step_size_select, enable, reset_n} = 3'h7;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    cy(2);
    t_regs();
    t_half();
    t_rev();
    t_full();
    t_ctl();
    t_chop();
    t_osc();
    end_of_test();
  end
endmodule : stepper_phase_translator_tb
